/* dv/lbs_checker.sv */
`timescale 1ns/1ns
module lbs_checker import lbs_pkg::*; (
  input wire logic core_clk, // Clock
  input wire logic rst, // Reset
  input wire logic cyc_ack, // Taken
  input wire logic cyc_done, // Finished
  input wire logic [2:0] cyc_type, // Type
  input wire logic [LBS_ADDR_W-1:0] cyc_addr, // Address
  input wire logic bus_req_in, // Request
  input wire logic [LBS_ADDR_W-1:0] upper_base, // Upper start
  input wire logic [LBS_ADDR_W-1:0] lower_top, // Lower end
  input wire logic cycle_status_bit0, // Status
  input wire logic cycle_status_bit1, // Status
  input wire logic cycle_status_bit2, // Status
  input wire logic status_oe_n, // Status enable
  input wire logic lock_n, // Lock
  input wire logic lock_oe_n, // Lock enable
  input wire logic bus_oe_n, // Bus enable
  input wire logic bus_grant_out, // Grant
  input wire logic upper_mem_select_n, // Upper select
  input wire logic lower_mem_select_n // Lower select
);
  // ----------
  // Properties
  // ----------
  logic [2:0] st;
  assign st = {cycle_status_bit2, cycle_status_bit1, cycle_status_bit0}; // Status code
  default clocking cb @(posedge core_clk); endclocking
  property p_rst; rst |-> st == LBS_ST_PASSIVE && !status_oe_n && lock_n && !lock_oe_n; endproperty
  a_rst: assert property (p_rst) else $error("reset drive");
  property p_code; disable iff (rst) cyc_ack |-> st == cyc_type && !status_oe_n; endproperty
  a_code: assert property (p_code) else $error("status code");
  property p_float; disable iff (rst) bus_grant_out |-> status_oe_n && bus_oe_n; endproperty
  a_float: assert property (p_float) else $error("float on grant");
  property p_drop; disable iff (rst) !bus_req_in [*8] |-> !bus_grant_out; endproperty
  a_drop: assert property (p_drop) else $error("grant kept");
  property p_sync; disable iff (rst) $rose(bus_req_in) && !bus_grant_out |=> !bus_grant_out [*2]; endproperty
  a_sync: assert property (p_sync) else $error("grant too early");
  property p_nofetch; disable iff (rst) !lock_n && !lock_oe_n |-> st != LBS_ST_FETCH; endproperty
  a_nofetch: assert property (p_nofetch) else $error("fetch while locked");
  property p_upper; disable iff (rst) cyc_ack |-> upper_mem_select_n == !(cyc_type[2] && cyc_addr >= upper_base); endproperty
  a_upper: assert property (p_upper) else $error("upper select");
  property p_lower; disable iff (rst) cyc_ack |-> lower_mem_select_n == !(cyc_type[2] && cyc_addr <= lower_top); endproperty
  a_lower: assert property (p_lower) else $error("lower select");
  property p_done; disable iff (rst) cyc_ack |-> ##4 cyc_done; endproperty
  a_done: assert property (p_done) else $error("cycle length");
  property p_relfloat; $fell(rst) |=> status_oe_n && lock_oe_n; endproperty
  a_relfloat: assert property (p_relfloat) else $error("float after reset");
endmodule : lbs_checker
bind lbs_bus_front lbs_checker lbs_checker_inst (.core_clk, .rst, .cyc_ack, .cyc_done, .cyc_type, .cyc_addr, .bus_req_in,
  .upper_base, .lower_top, .cycle_status_bit0, .cycle_status_bit1, .cycle_status_bit2, .status_oe_n, .lock_n,
  .lock_oe_n, .bus_oe_n, .bus_grant_out, .upper_mem_select_n, .lower_mem_select_n);

/* dv/lbs_master_model.sv */
`timescale 1ns/1ns
module lbs_master_model (
  input wire logic core_clk, // Clock
  input wire logic want, // Bench asks for a tenure
  input wire logic [3:0] hold, // Clocks to keep the bus
  input wire logic bus_grant_out, // Grant
  output logic bus_req_in // Request, off the clock edge
);
  int n;
  // One tenure: request, wait for grant, keep the bus, release
  initial begin
    bus_req_in = 1'b0;
    forever begin
      @(posedge core_clk);
      if (want) begin
        n = 0;
        #17 bus_req_in = 1'b1;
        while (!bus_grant_out && n < 200) begin
          @(posedge core_clk);
          n++;
        end
        repeat (hold) @(posedge core_clk);
        #9 bus_req_in = 1'b0;
        while (bus_grant_out && n < 400) begin
          @(posedge core_clk);
          n++;
        end
      end
    end
  end
endmodule : lbs_master_model

/* dv/local_bus_status_hold_chip_select_tb.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module local_bus_status_hold_chip_select_tb import lbs_pkg::*; ;
  logic core_clk, rst, cyc_req, cyc_ack, lock_prefix, instr_end, bus_req_in, want, s0, s1, s2;
  logic status_oe_n, lock_n, lock_oe_n, bus_oe_n, bus_grant_out, upper_n, lower_n;
  logic [2:0] cyc_type;
  logic [3:0] hold;
  logic [4:0] exp_v;
  logic [4:0] exp_q[$];
  logic [LBS_ADDR_W-1:0] cyc_addr, upper_base, lower_top, r;
  int mismatches, checked, seed, i, n;
  lbs_bus_front lbs_bus_front_inst (.core_clk, .rst, .cyc_req, .cyc_type, .cyc_addr, .cyc_ack, .cyc_done(),
    .lock_prefix, .instr_end, .bus_req_in, .upper_base, .lower_top, .cycle_status_bit0(s0),
    .cycle_status_bit1(s1), .cycle_status_bit2(s2), .status_oe_n, .lock_n, .lock_oe_n, .bus_oe_n,
    .bus_grant_out, .upper_mem_select_n(upper_n), .lower_mem_select_n(lower_n));
  lbs_master_model lbs_master_model_inst (.core_clk, .want, .hold, .bus_grant_out, .bus_req_in);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // Present a cycle and note what it must show
  task automatic issue(input logic [2:0] t, input logic [LBS_ADDR_W-1:0] a);
    @(posedge core_clk);
    cyc_req <= 1'b1;
    cyc_type <= t;
    cyc_addr <= a;
    exp_q.push_back({t, !(t[2] && a >= upper_base), !(t[2] && a <= lower_top)});
  endtask : issue
  task automatic await;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (cyc_ack !== 1'b1 && n < 300);
    if (n >= 300) begin
      mismatches++;
      results;
    end
    cyc_req <= 1'b0;
  endtask : await
  // Match each taken cycle with the oldest note
  always @(negedge core_clk) begin
    if (cyc_ack === 1'b1) begin
      exp_v = exp_q.pop_front();
      `CHK("status", exp_v[4:2], {s2, s1, s0})
      `CHK("selects", exp_v[1:0], {upper_n, lower_n})
    end
  end
  // Reset, random traffic with a grant, explicit grant, locked sequence
  initial begin
    seed = 32'h30753ad5;
    {rst, cyc_req, lock_prefix, instr_end, want} = 5'h00;
    #1 rst = 1'b1;
    cyc_type = LBS_ST_PASSIVE;
    cyc_addr = 20'h0_0000;
    hold = 4'h2;
    upper_base = 20'hF_0000 | 20'($random(seed));
    lower_top = LBS_LOWER_MIN_TOP | (20'($random(seed)) & 20'h3_FC00);
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    for (i = 0; i < 24; i++) begin
      r = 20'($random(seed));
      issue(3'(i % 7), i[0] ? (upper_base | r) : (r & lower_top));
      want <= (i == 9);
      hold <= 4'(r);
      await;
    end
    want <= 1'b1;
    hold <= 4'hF;
    @(posedge core_clk);
    want <= 1'b0;
    n = 0;
    while (bus_grant_out !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 100) begin
      mismatches++;
      results;
    end
    `CHK("float", 2'h3, {bus_oe_n, status_oe_n})
    `CHK("held selects", 2'h3, {upper_n, lower_n})
    issue(LBS_ST_MEMRD, lower_top);
    await;
    @(negedge core_clk);
    `CHK("regain", 2'h0, {bus_grant_out, bus_oe_n})
    @(posedge core_clk);
    lock_prefix <= 1'b1;
    issue(LBS_ST_MEMWR, 20'h0_0010);
    await;
    lock_prefix <= 1'b0;
    @(negedge core_clk);
    `CHK("lock_n", 2'h0, {lock_n, lock_oe_n})
    issue(LBS_ST_FETCH, 20'h0_0020);
    want <= 1'b1;
    hold <= 4'h3;
    repeat (10) @(negedge core_clk);
    `CHK("locked grant", 1'b0, bus_grant_out)
    `CHK("fetch held", 1, exp_q.size())
    @(posedge core_clk);
    instr_end <= 1'b1;
    want <= 1'b0;
    @(posedge core_clk);
    instr_end <= 1'b0;
    await;
    repeat (8) @(negedge core_clk);
    `CHK("passive", LBS_ST_PASSIVE, {s2, s1, s0})
    results;
  end
endmodule : local_bus_status_hold_chip_select_tb

/* rtl/lbs_bus_front.sv */
`timescale 1ns/1ns
module lbs_bus_front
  import lbs_pkg::*;
(
  input wire logic core_clk, // Processor clock, 20 MHz
  input wire logic rst, // Async reset, active high
  input wire logic cyc_req, // Core has a bus cycle pending
  input wire logic [2:0] cyc_type, // Cycle type code for the pending cycle
  input wire logic [LBS_ADDR_W-1:0] cyc_addr, // Physical address of pending cycle
  output logic cyc_ack, // Pulse: pending cycle taken
  output logic cyc_done, // Pulse: cycle finished its final state
  input wire logic lock_prefix, // Next instruction is locked
  input wire logic instr_end, // Pulse: current instruction completes
  input wire logic bus_req_in, // Request from other master, async
  input wire logic [LBS_ADDR_W-1:0] upper_base, // Start of upper select region
  input wire logic [LBS_ADDR_W-1:0] lower_top, // Last address of lower select region
  output logic cycle_status_bit0, // Status low bit
  output logic cycle_status_bit1, // Status middle bit, data direction
  output logic cycle_status_bit2, // Status high bit, memory vs io
  output logic status_oe_n, // Status pins enable, low drives
  output logic lock_n, // Exclusive access, active low
  output logic lock_oe_n, // Exclusive access enable, low drives
  output logic bus_oe_n, // Local bus and control enable, low drives
  output logic bus_grant_out, // Grant to other master
  output logic upper_mem_select_n, // Upper memory select, always driven
  output logic lower_mem_select_n // Lower memory select, always driven
);
  lbs_state_t state;
  logic req_sync;
  logic [1:0] tstate;
  logic rst_seen;
  logic lock_armed;
  logic lock_active;
  logic [2:0] cur_type;
  logic [LBS_ADDR_W-1:0] lower_lim;
  logic take;
  logic boundary;
  logic grant_now;
  logic start_cyc;
  logic end_cyc;
  logic lock_start;
  logic mem_ref;

  // ------------------------------------------------------------
  // Request synchroniser
  // ------------------------------------------------------------
  lbs_req_sync #(.STAGES(LBS_SYNC_STAGES)) u_req_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(bus_req_in),
    .level_out(req_sync)
  );

  // Cycle boundary: end of final state, or an idle clock
  assign boundary = (state == LBS_IDLE) || (state == LBS_CYCLE && tstate == LBS_LAST_STATE);
  // Prefetch held off while locked
  assign take = cyc_req && !(lock_active && cyc_type == LBS_ST_FETCH);
  // Clamp lower region to its legal size range
  assign lower_lim = (lower_top < LBS_LOWER_MIN_TOP) ? LBS_LOWER_MIN_TOP :
                     (lower_top > LBS_LOWER_MAX_TOP) ? LBS_LOWER_MAX_TOP : lower_top;

  // Decisions shared by the handshake, grant, status, lock and select processes; the bus sequencer derives its own
  assign end_cyc = (state == LBS_CYCLE) && (tstate == LBS_LAST_STATE);
  assign grant_now = boundary && req_sync && !lock_active;
  assign start_cyc = boundary && take && !grant_now;
  // Lock only opens on a data cycle, a fetch never starts it
  assign lock_start = lock_armed && start_cyc && (cyc_type != LBS_ST_FETCH);
  // Fetch, memory read and memory write reach the selects
  assign mem_ref = cyc_type[2] && (cyc_type != LBS_ST_PASSIVE);

  // ------------------------------------------------------------
  // Bus sequencer
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= LBS_RESET;
      tstate <= 2'h0;
      cur_type <= LBS_ST_PASSIVE;
    end else begin
      case (state)
        LBS_RESET: begin
          state <= LBS_IDLE;
        end
        LBS_IDLE, LBS_CYCLE: begin
          if (state == LBS_CYCLE && tstate != LBS_LAST_STATE) begin
            tstate <= tstate + 2'h1;
          end else if (req_sync && !lock_active) begin
            state <= LBS_GRANTED;
          end else if (take) begin
            state <= LBS_CYCLE;
            tstate <= 2'h0;
            cur_type <= cyc_type;
          end else begin
            state <= LBS_IDLE;
          end
        end
        LBS_GRANTED: begin
          if (!req_sync) begin
            state <= LBS_IDLE;
          end
        end
        default: begin
          state <= LBS_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Handshake pulses to the core
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cyc_ack <= 1'b0;
      cyc_done <= 1'b0;
    end else begin
      cyc_ack <= start_cyc;
      cyc_done <= end_cyc;
    end
  end

  // ------------------------------------------------------------
  // Grant to the other master
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_grant_out <= 1'b0;
    end else if (grant_now) begin
      bus_grant_out <= 1'b1;
    end else if (state == LBS_GRANTED && !req_sync) begin
      bus_grant_out <= 1'b0;
    end
  end

  // Local bus enable: floats with the grant, driven again by the next cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_oe_n <= 1'b1;
    end else if (grant_now) begin
      bus_oe_n <= 1'b1;
    end else if (start_cyc) begin
      bus_oe_n <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Status pins
  // ------------------------------------------------------------
  // Status enable: driven in reset, floats until the first cycle and during grant
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_oe_n <= 1'b0;
    end else if (grant_now) begin
      status_oe_n <= 1'b1;
    end else if (start_cyc) begin
      status_oe_n <= 1'b0;
    end else if (state == LBS_RESET || (state == LBS_IDLE && !rst_seen)) begin
      status_oe_n <= 1'b1;
    end
  end

  // Status code: type for the whole cycle, passive between cycles except through a grant taken at the cycle end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {cycle_status_bit2, cycle_status_bit1, cycle_status_bit0} <= LBS_ST_PASSIVE;
    end else if (start_cyc) begin
      // Encoded type: bit2 memory/io, bit1 write/read
      {cycle_status_bit2, cycle_status_bit1, cycle_status_bit0} <= cyc_type;
    end else if (!grant_now && (end_cyc || (state == LBS_IDLE && rst_seen))) begin
      {cycle_status_bit2, cycle_status_bit1, cycle_status_bit0} <= LBS_ST_PASSIVE;
    end
  end

  // First cycle after reset seen: ends the post-reset float
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rst_seen <= 1'b0;
    end else if (start_cyc) begin
      rst_seen <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Exclusive access tracking
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lock_armed <= 1'b0;
      lock_active <= 1'b0;
      lock_n <= 1'b1;
      lock_oe_n <= 1'b0;
    end else begin
      if (lock_active && instr_end) begin
        lock_active <= 1'b0;
        lock_n <= 1'b1;
      end else if (lock_start) begin
        lock_active <= 1'b1;
        lock_armed <= 1'b0;
        lock_n <= 1'b0;
        lock_oe_n <= 1'b0;
      end else if (lock_prefix && !lock_active) begin
        // A prefix seen while already locked must not arm a later cycle
        lock_armed <= 1'b1;
      end
      if (!lock_active && !lock_start) begin
        lock_oe_n <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Memory selects, driven even while granted
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      upper_mem_select_n <= 1'b1;
      lower_mem_select_n <= 1'b1;
    end else if (start_cyc && mem_ref) begin
      upper_mem_select_n <= !(cyc_addr >= upper_base);
      lower_mem_select_n <= !(cyc_addr <= lower_lim);
    end else if (state != LBS_CYCLE || tstate == LBS_LAST_STATE) begin
      upper_mem_select_n <= 1'b1;
      lower_mem_select_n <= 1'b1;
    end
  end
endmodule : lbs_bus_front

/* rtl/lbs_pkg.sv */
// Summary of operation
// - Status code order is int ack, io read, io write, halt, fetch, mem read, mem write, passive.
// - The middle status bit alone tells write (high) from read (low).
// - The top status bit alone tells memory (high) from io (low).
// - All three status outputs float while the bus is granted away.
// - In reset the status outputs are driven high, then float until the first bus cycle.
// - The exclusive access output asserts at the first data cycle after a lock prefix and holds to instruction end.
// - No prefetch cycles run while exclusive access is asserted.
// - In reset the exclusive access output is driven high, then floats from the first clock after reset.
// - A request input asks for the bus; grant asserts together with floating the bus lines.
// - Grant asserts only at a cycle boundary, end of final or idle state, with outputs floated that clock.
// - Grant drops once the request is sampled low; bus lines are driven again for the next cycle.
// - Upper memory select goes low for references in the top region and stays driven during grant.
// - Lower memory select goes low for references in the bottom region of 1K to 256K and stays driven.
// - Exclusive access output is active low.
package lbs_pkg;
  // ----------------------------------------------------------------
  // Cycle status codes
  // ----------------------------------------------------------------
  localparam logic [2:0] LBS_ST_INTA = 3'h0;
  localparam logic [2:0] LBS_ST_IORD = 3'h1;
  localparam logic [2:0] LBS_ST_IOWR = 3'h2;
  localparam logic [2:0] LBS_ST_HALT = 3'h3;
  localparam logic [2:0] LBS_ST_FETCH = 3'h4;
  localparam logic [2:0] LBS_ST_MEMRD = 3'h5;
  localparam logic [2:0] LBS_ST_MEMWR = 3'h6;
  localparam logic [2:0] LBS_ST_PASSIVE = 3'h7;
  // ----------------------------------------------------------------
  // Timing and sizes
  // ----------------------------------------------------------------
  localparam int LBS_SYNC_STAGES = 3;
  localparam int LBS_CYCLE_STATES = 4;
  localparam logic [1:0] LBS_LAST_STATE = 2'h3;
  localparam int LBS_ADDR_W = 20;
  localparam logic [LBS_ADDR_W-1:0] LBS_UPPER_BASE_RST = 20'hF_FC00;
  localparam logic [LBS_ADDR_W-1:0] LBS_LOWER_TOP_RST = 20'h0_03FF;
  localparam logic [LBS_ADDR_W-1:0] LBS_LOWER_MIN_TOP = 20'h0_03FF;
  localparam logic [LBS_ADDR_W-1:0] LBS_LOWER_MAX_TOP = 20'h3_FFFF;
  // ----------------------------------------------------------------
  // Bus sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LBS_RESET = 2'b00,
    LBS_IDLE = 2'b01,
    LBS_CYCLE = 2'b10,
    LBS_GRANTED = 2'b11
  } lbs_state_t;
endpackage : lbs_pkg

/* rtl/lbs_req_sync.sv */
`timescale 1ns/1ns
module lbs_req_sync
  import lbs_pkg::*;
#(
  parameter int STAGES = LBS_SYNC_STAGES
) (
  input wire logic core_clk, // Processor clock
  input wire logic rst, // Async reset, active high
  input wire logic async_in, // Raw pin level
  output logic level_out // Debounced synchronised level
);
  logic [STAGES-1:0] sync_chain;

  // ------------------------------------------------------------
  // Synchroniser chain, stage 0 only feeds stage 1
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_chain <= '0;
    end else begin
      sync_chain <= {sync_chain[STAGES-2:0], async_in};
    end
  end

  // Accept a change once the last two stages agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      level_out <= 1'b0;
    end else if (sync_chain[STAGES-1] == sync_chain[STAGES-2]) begin
      level_out <= sync_chain[STAGES-1];
    end
  end
endmodule : lbs_req_sync
